/* File: core/fpc_pkg.sv */
/*
 * Constants, register map and carrier types of the fan PWM controller core.
 * Assumes a single 10 MHz clock and an APB master with 32-bit data.
 */
// What this block does
// - Voltage 1.62..2.6 V maps 30..100% duty
// - Alert low while fan speed below threshold
// - Count pulses per fan for speed
// - PWM output active high, always driven
// - Above 2.6 V sets overtemp flag
// - Overtemp variant also holds alert low
// - Fixed period, only high time changes
// - Reference capacitor gives about 30 Hz
// - One second full-on burst after start
// - After burst, source select picks duty
// - Source select resets to voltage input
// - Open voltage input gives 39.33% duty
// - Frequency inversely proportional to capacitor
// - Four-bit code gives sixteen duty steps
// - Only shutdown stops PWM, faults do not
package fpc_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 10000000;
	localparam int PWM_REF_HZ = 30;
	localparam int CAP_REF_NF = 1000;
	localparam int CAP_SCALE = 10;
	localparam int PWM_STEPS = 300;
	localparam int STARTUP_TIME_MS = 1000;
	localparam int MS_PER_S = 1000;
	localparam int STARTUP_PERIODS_DEF = STARTUP_TIME_MS * PWM_REF_HZ / MS_PER_S;
	localparam int MEAS_PERIODS_DEF = STARTUP_PERIODS_DEF;
	// Ramp increment per clock so that the reference capacitor yields the reference rate.
	localparam int ACC_INC = PWM_REF_HZ * PWM_STEPS * CAP_REF_NF / (CLK_HZ / CAP_SCALE);

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int STEP_W = 9;
	localparam int ACC_W = 21;
	localparam int CAP_W = 16;
	localparam int CNT_W = 16;
	localparam int MV_W = 12;
	localparam int CODE_W = 4;
	localparam int STAT_W = 8;

	// ----------------------------------------
	// Duty mapping in steps of one period
	// ----------------------------------------
	localparam int VIN_LO_MV = 1620;
	localparam int VIN_HI_MV = 2600;
	localparam int DUTY_MIN_STEPS = 90;
	localparam int DUTY_CODE_STEP = 14;
	localparam int OPEN_CODE = 2;
	localparam int OPEN_STEPS = DUTY_MIN_STEPS + OPEN_CODE * DUTY_CODE_STEP;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] ADDR_CFG = 12'h000;
	localparam logic [11:0] ADDR_DUTY = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;
	localparam logic [11:0] ADDR_MASK = 12'h00c;
	localparam logic [11:0] ADDR_CAP = 12'h010;
	localparam logic [11:0] ADDR_THRESH = 12'h014;
	localparam logic [11:0] ADDR_FAN1 = 12'h018;
	localparam logic [11:0] ADDR_FAN2 = 12'h01c;
	localparam logic [11:0] ADDR_INFO = 12'h020;
	localparam int CFG_SD_BIT = 0;
	localparam int CFG_DSS_BIT = 5;
	localparam int ST_F1_BIT = 0;
	localparam int ST_F2_BIT = 1;
	localparam int ST_OT_BIT = 5;
	localparam logic [STAT_W-1:0] STAT_IMPL = 8'h23;
	localparam int INFO_MODE_LSB = 16;
	localparam logic [CODE_W-1:0] DUTY_CODE_RST = 4'h2;
	localparam logic [CAP_W-1:0] CAP_RST = 16'h03e8;
	localparam logic [CNT_W-1:0] THRESH_RST = 16'h0010;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_STARTUP = 2'b00,
		ST_RUN = 2'b01,
		ST_SHUT = 2'b10
	} fpc_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} fpc_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} fpc_apb_rsp_t;

	typedef struct packed {
		logic [ACC_W-1:0] acc;
		logic [STEP_W-1:0] step;
		logic wrap;
	} fpc_ramp_t;

	typedef struct packed {
		logic prev;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] result;
		logic valid;
	} fpc_cnt_t;

	typedef struct packed {
		fpc_mode_t mode;
		logic [7:0] burst;
		logic [7:0] meas;
		logic [STEP_W-1:0] high;
		logic pwm;
		logic sd;
		logic dss;
		logic [CODE_W-1:0] code;
		logic [STAT_W-1:0] status;
		logic [STAT_W-1:0] mask;
		logic [CAP_W-1:0] cap;
		logic [CNT_W-1:0] thresh;
		logic below1;
		logic below2;
		logic alert;
		logic [31:0] prdata;
	} fpc_top_t;

	// Source select starts on voltage input.
	localparam fpc_top_t TOP_RST = '{mode: ST_STARTUP, code: DUTY_CODE_RST, cap: CAP_RST,
		thresh: THRESH_RST, default: '0};

endpackage

/* File: core/fpc_ramp_div.sv */
/*
 * Ramp oscillator model: divides the clock into PWM steps and periods.
 * Assumes cap_nf holds the timing capacitance in nF; zero is taken as one.
 */
`timescale 1ns/1ps
module fpc_ramp_div
	import fpc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [CAP_W-1:0] cap_nf,
	output logic [STEP_W-1:0] step,
	output logic wrap
);

	fpc_ramp_t r_reg;
	fpc_ramp_t r_next;
	logic [ACC_W-1:0] sum;
	logic [ACC_W-1:0] lim;

	always_comb
	begin
		r_next = r_reg;
		r_next.wrap = 1'b0;
		sum = r_reg.acc + ACC_W'(ACC_INC);
		lim = ACC_W'((cap_nf == '0 ? CAP_W'(1) : cap_nf) * CAP_SCALE);
		if (!run)
		begin
			r_next.acc = '0;
			r_next.step = '0;
		end
		else if (sum >= lim)
		begin
			r_next.acc = sum - lim;
			if (r_reg.step == STEP_W'(PWM_STEPS - 1))
			begin
				r_next.step = '0;
				r_next.wrap = 1'b1;
			end
			else
				r_next.step = r_reg.step + STEP_W'(1);
		end
		else
			r_next.acc = sum;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign step = r_reg.step;
	assign wrap = r_reg.wrap;

endmodule

/* File: core/fpc_pulse_counter.sv */
/*
 * Fan pulse counter: counts rising edges over a measurement window.
 * Assumes pulse_in is already a clean level synchronous to ref_clk.
 */
`timescale 1ns/1ps
module fpc_pulse_counter
	import fpc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic run,
	input wire logic pulse_in,
	input wire logic window_end,
	output logic [CNT_W-1:0] result,
	output logic valid
);

	fpc_cnt_t c_reg;
	fpc_cnt_t c_next;
	logic [CNT_W-1:0] inc;

	always_comb
	begin
		c_next = c_reg;
		c_next.valid = 1'b0;
		c_next.prev = pulse_in;
		inc = c_reg.cnt;
		if (pulse_in && !c_reg.prev && c_reg.cnt != '1)
			inc = c_reg.cnt + CNT_W'(1);
		if (!run)
			c_next.cnt = '0;
		else if (window_end)
		begin
			c_next.result = inc;
			c_next.cnt = '0;
			c_next.valid = 1'b1;
		end
		else
			c_next.cnt = inc;
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			c_reg <= '0;
		else
			c_reg <= c_next;
	end

	assign result = c_reg.result;
	assign valid = c_reg.valid;

endmodule

/* File: core/fpc_top.sv */
/*
 * Fan PWM controller top: APB registers, start-up burst, duty selection,
 * PWM generation, fan speed supervision, alert and interrupt.
 * Assumes all inputs synchronous to ref_clk; temp_voltage_in is in mV.
 */
`timescale 1ns/1ps
module fpc_top
	import fpc_pkg::*;
#(
	parameter bit OT_ALERT_EN = 1'b1,
	parameter int unsigned STARTUP_PERIODS = STARTUP_PERIODS_DEF,
	parameter int unsigned MEAS_PERIODS = MEAS_PERIODS_DEF
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire fpc_apb_req_t apb_req,
	output fpc_apb_rsp_t apb_rsp,
	input wire logic [MV_W-1:0] temp_voltage_in,
	input wire logic temp_voltage_open,
	input wire logic fan1_pulse_in,
	input wire logic fan2_pulse_in,
	output logic pwm_drive_out,
	output logic alert_n_out,
	output logic alert_oe,
	output logic irq_out
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	fpc_top_t st_reg;
	fpc_top_t st_next;
	logic [STEP_W-1:0] step;
	logic period_end;
	logic window_end;
	logic counting;
	logic [CNT_W-1:0] fan1_count;
	logic [CNT_W-1:0] fan2_count;
	logic fan1_valid;
	logic fan2_valid;
	logic [STEP_W-1:0] vin_steps;
	logic [STEP_W-1:0] code_steps;
	logic [STEP_W-1:0] src_steps;
	logic overtemp;
	logic acc_wr;
	logic setup;
	logic addr_err;
	logic [31:0] rd_val;
	logic [STAT_W-1:0] clr_bits;
	logic [STAT_W-1:0] set_bits;

	// ----------------------------------------
	// Duty sources
	// ----------------------------------------
	// Clamped linear voltage mapping.
	assign vin_steps = temp_voltage_open ? STEP_W'(OPEN_STEPS) :
		(int'(temp_voltage_in) <= VIN_LO_MV) ? STEP_W'(DUTY_MIN_STEPS) :
		(int'(temp_voltage_in) >= VIN_HI_MV) ? STEP_W'(PWM_STEPS) :
		STEP_W'(DUTY_MIN_STEPS + (int'(temp_voltage_in) - VIN_LO_MV) *
		(PWM_STEPS - DUTY_MIN_STEPS) / (VIN_HI_MV - VIN_LO_MV));
	assign code_steps = STEP_W'(DUTY_MIN_STEPS + int'(st_reg.code) * DUTY_CODE_STEP);
	assign src_steps = st_reg.dss ? code_steps : vin_steps;
	assign overtemp = int'(temp_voltage_in) > VIN_HI_MV;

	// ----------------------------------------
	// Bus decode, run enable and measurement window
	// ----------------------------------------
	assign setup = apb_req.psel && !apb_req.penable;
	assign acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign counting = st_reg.mode != ST_SHUT;
	assign window_end = period_end && st_reg.meas == 8'(MEAS_PERIODS - 1);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		st_next = st_reg;
		clr_bits = '0;
		set_bits = '0;
		rd_val = '0;
		addr_err = 1'b0;
		case (apb_req.paddr)
			ADDR_CFG:
			begin
				rd_val[CFG_SD_BIT] = st_reg.sd;
				rd_val[CFG_DSS_BIT] = st_reg.dss;
			end
			ADDR_DUTY: rd_val[CODE_W-1:0] = st_reg.code;
			ADDR_STAT: rd_val[STAT_W-1:0] = st_reg.status;
			ADDR_MASK: rd_val[STAT_W-1:0] = st_reg.mask;
			ADDR_CAP: rd_val[CAP_W-1:0] = st_reg.cap;
			ADDR_THRESH: rd_val[CNT_W-1:0] = st_reg.thresh;
			ADDR_FAN1: rd_val[CNT_W-1:0] = fan1_count;
			ADDR_FAN2: rd_val[CNT_W-1:0] = fan2_count;
			ADDR_INFO:
			begin
				rd_val[STEP_W-1:0] = st_reg.high;
				rd_val[INFO_MODE_LSB +: 2] = st_reg.mode;
			end
			default: addr_err = 1'b1;
		endcase
		if (setup)
			st_next.prdata = rd_val;
		if (acc_wr)
		begin
			case (apb_req.paddr)
				ADDR_CFG:
				begin
					st_next.sd = apb_req.pwdata[CFG_SD_BIT];
					st_next.dss = apb_req.pwdata[CFG_DSS_BIT];
				end
				ADDR_DUTY: st_next.code = apb_req.pwdata[CODE_W-1:0];
				ADDR_STAT: clr_bits = apb_req.pwdata[STAT_W-1:0];
				ADDR_MASK: st_next.mask = apb_req.pwdata[STAT_W-1:0] & STAT_IMPL;
				ADDR_CAP: st_next.cap = apb_req.pwdata[CAP_W-1:0];
				ADDR_THRESH: st_next.thresh = apb_req.pwdata[CNT_W-1:0];
				default: ;
			endcase
		end

		// Fan speed supervision; a stopped core reports no fan fault.
		if (!counting)
		begin
			st_next.below1 = 1'b0;
			st_next.below2 = 1'b0;
			st_next.meas = '0;
		end
		else
		begin
			if (period_end)
				st_next.meas = window_end ? '0 : st_reg.meas + 8'(1);
			if (fan1_valid)
				st_next.below1 = fan1_count < st_reg.thresh;
			if (fan2_valid)
				st_next.below2 = fan2_count < st_reg.thresh;
		end
		set_bits[ST_F1_BIT] = fan1_valid && fan1_count < st_reg.thresh;
		set_bits[ST_F2_BIT] = fan2_valid && fan2_count < st_reg.thresh;
		set_bits[ST_OT_BIT] = overtemp;
		// Sticky flags: a new event wins over a clear in the same cycle.
		st_next.status = ((st_reg.status & ~clr_bits) | set_bits) & STAT_IMPL;
		st_next.alert = st_reg.below1 || st_reg.below2 || (OT_ALERT_EN && overtemp);

		case (st_reg.mode)
			ST_STARTUP:
			begin
				st_next.pwm = 1'b1;
				if (period_end)
				begin
					if (st_reg.burst == 8'(STARTUP_PERIODS - 1))
					begin
						st_next.mode = ST_RUN;
						st_next.high = src_steps;
						st_next.burst = '0;
					end
					else
						st_next.burst = st_reg.burst + 8'(1);
				end
			end
			ST_RUN:
			begin
				if (period_end)
					st_next.high = src_steps;
				st_next.pwm = step < st_reg.high;
			end
			ST_SHUT:
			begin
				st_next.pwm = 1'b0;
				if (!st_reg.sd)
				begin
					st_next.mode = ST_STARTUP;
					st_next.burst = '0;
				end
			end
			default: st_next.mode = ST_STARTUP;
		endcase
		if (st_reg.sd)
		begin
			st_next.mode = ST_SHUT;
			st_next.pwm = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			st_reg <= TOP_RST;
		else
			st_reg <= st_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Push-pull active-high drive.
	assign pwm_drive_out = st_reg.pwm;
	assign alert_n_out = !st_reg.alert;
	assign alert_oe = st_reg.alert;
	assign irq_out = |(st_reg.status & st_reg.mask);
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && addr_err;
	assign apb_rsp.prdata = st_reg.prdata;

	// ----------------------------------------
	// Ramp and fan counters
	// ----------------------------------------
	fpc_ramp_div u_ramp (
		.ref_clk(ref_clk),
		.srst(srst),
		.run(counting),
		.cap_nf(st_reg.cap),
		.step(step),
		.wrap(period_end)
	);

	fpc_pulse_counter u_fan1 (
		.ref_clk(ref_clk),
		.srst(srst),
		.run(counting),
		.pulse_in(fan1_pulse_in),
		.window_end(window_end),
		.result(fan1_count),
		.valid(fan1_valid)
	);

	fpc_pulse_counter u_fan2 (
		.ref_clk(ref_clk),
		.srst(srst),
		.run(counting),
		.pulse_in(fan2_pulse_in),
		.window_end(window_end),
		.result(fan2_count),
		.valid(fan2_valid)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_VIN_LOW: assert property (@(posedge ref_clk) disable iff (srst)
		!temp_voltage_open && int'(temp_voltage_in) <= VIN_LO_MV |-> vin_steps == DUTY_MIN_STEPS)
		else $error("low voltage does not give minimum duty");
	AST_ALERT_FAN: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.below1 || st_reg.below2 |=> alert_oe && !alert_n_out)
		else $error("slow fan did not assert alert");
	AST_OT_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
		overtemp |=> st_reg.status[ST_OT_BIT])
		else $error("overtemperature flag not set");
	AST_ALERT_OT: assert property (@(posedge ref_clk) disable iff (srst)
		OT_ALERT_EN && overtemp |=> alert_oe)
		else $error("overtemperature did not assert alert");
	AST_HIGH_STABLE: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.mode == ST_RUN && !period_end |=> $stable(st_reg.high))
		else $error("high time changed inside a period");
	AST_STARTUP_HIGH: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.mode == ST_STARTUP && $past(st_reg.mode) == ST_STARTUP && !$past(srst) |->
		pwm_drive_out)
		else $error("output not full on during burst");
	AST_SRC_PICK: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.mode == ST_STARTUP && st_next.mode == ST_RUN |=>
		st_reg.high == $past(src_steps))
		else $error("wrong duty source after burst");
	AST_RESET_SRC: assert property (@(posedge ref_clk) disable iff (srst)
		$past(srst) |-> !st_reg.dss && st_reg.mode == ST_STARTUP)
		else $error("reset state wrong");
	AST_OPEN_DUTY: assert property (@(posedge ref_clk) disable iff (srst)
		temp_voltage_open |-> vin_steps == OPEN_STEPS)
		else $error("open input duty wrong");
	AST_CODE_FULL: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.code == '1 |-> code_steps == PWM_STEPS)
		else $error("top code is not full duty");
	AST_SHUT_LOW: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.mode == ST_SHUT |-> !pwm_drive_out)
		else $error("output active in shutdown");
	AST_FAULT_RUNS: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.mode == ST_RUN && st_reg.below1 && !st_reg.sd |=> st_reg.mode == ST_RUN)
		else $error("fan fault stopped the output");
	AST_BURST_END: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.mode == ST_STARTUP && period_end && !st_reg.sd &&
		st_reg.burst == 8'(STARTUP_PERIODS - 1) |=> st_reg.mode == ST_RUN)
		else $error("burst did not end after its periods");
	AST_RUN_PWM: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.mode == ST_RUN && !st_reg.sd |=> pwm_drive_out == ($past(step) < $past(st_reg.high)))
		else $error("output high time does not follow the latched duty");
	AST_FAN1_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
		fan1_valid && fan1_count < st_reg.thresh |=> st_reg.status[ST_F1_BIT])
		else $error("slow first fan did not set its flag");
	AST_FAN2_FLAG: assert property (@(posedge ref_clk) disable iff (srst)
		fan2_valid && fan2_count < st_reg.thresh |=> st_reg.status[ST_F2_BIT])
		else $error("slow second fan did not set its flag");
	AST_SHUT_ENTRY: assert property (@(posedge ref_clk) disable iff (srst)
		st_reg.sd |=> st_reg.mode == ST_SHUT && !pwm_drive_out)
		else $error("shutdown bit did not stop the output");

endmodule

/* File: bench/fpc_fan_model.sv */
/*
 * Fan pair model: two brushless fans giving tach pulses on their sense lines.
 * Assumes a 10 MHz ref_clk; a stalled fan holds its line low.
 */
`timescale 1ns/1ps
module fpc_fan_model
#(
	parameter int HALF = 10
)
(
	input wire logic ref_clk,
	input wire logic slow,
	input wire logic [1:0] stall,
	output logic fan1_pulse,
	output logic fan2_pulse
);
	int cnt = 0;
	logic tog = 1'b0;

	// A slow fan pulses at half rate so its count falls under a raised threshold.
	always @(posedge ref_clk)
	begin
		cnt <= (cnt >= (slow ? 2 * HALF : HALF) - 1) ? 0 : cnt + 1;
		if (cnt == 0)
			tog <= ~tog;
	end
	assign fan1_pulse = tog & ~stall[0];
	assign fan2_pulse = tog & ~stall[1];
endmodule

/* File: bench/fpc_top_bench.sv */
/*
 * Self-checking bench of the fan PWM controller top, driven over APB.
 * Assumes the fan pair model on the sense lines and a 10 MHz ref_clk.
 */
`timescale 1ns/1ps
module fpc_top_bench
	import fpc_pkg::*;
;
	localparam int SP = 2;
	localparam int FCNT = SP * PWM_STEPS * CAP_SCALE / ACC_INC / 20;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	fpc_apb_req_t req = '0;
	fpc_apb_rsp_t rsp;
	logic [MV_W-1:0] mv = 12'h3e8;
	logic open = 1'b0;
	logic slow = 1'b0;
	logic [1:0] stall = 2'h0;
	logic f1, f2, pwm, alert_n, alert_oe, irq, perr, alert_line;
	logic [31:0] rdat;
	int fail_count = 0;
	int num_checks = 0;
	int ones, rises;

	// The alert pin is open drain with a pull-up.
	assign alert_line = alert_oe ? 1'b0 : 1'b1;

	fpc_top #(.STARTUP_PERIODS(SP), .MEAS_PERIODS(SP)) DUT (.ref_clk(ref_clk), .srst(srst),
		.apb_req(req), .apb_rsp(rsp), .temp_voltage_in(mv), .temp_voltage_open(open),
		.fan1_pulse_in(f1), .fan2_pulse_in(f2), .pwm_drive_out(pwm), .alert_n_out(alert_n),
		.alert_oe(alert_oe), .irq_out(irq));
	fpc_fan_model fans (.ref_clk(ref_clk), .slow(slow), .stall(stall), .fan1_pulse(f1),
		.fan2_pulse(f2));

	initial
	begin
		forever #50 ref_clk = ~ref_clk;
	end

	// ------
	// Tasks
	// ------
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1)
		begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	function automatic logic inr(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		return v >= lo && v <= hi;
	endfunction

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge ref_clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge ref_clk);
		end
		while (rsp.pready !== 1'b1);
		rdat = rsp.prdata;
		perr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic meas(input int n);
		logic prev;
		ones = 0;
		rises = 0;
		prev = pwm;
		repeat (n)
		begin
			@(posedge ref_clk);
			ones += (pwm === 1'b1);
			rises += (pwm === 1'b1 && prev !== 1'b1);
			prev = pwm;
		end
	endtask

	function automatic int vsteps(input int v, input logic o);
		if (o)
			return OPEN_STEPS;
		if (v <= VIN_LO_MV)
			return DUTY_MIN_STEPS;
		if (v >= VIN_HI_MV)
			return PWM_STEPS;
		return DUTY_MIN_STEPS + (v - VIN_LO_MV) * (PWM_STEPS - DUTY_MIN_STEPS)
			/ (VIN_HI_MV - VIN_LO_MV);
	endfunction

	task automatic duty_case(input int steps);
		cyc(700);
		meas(1000);
		chk(inr(ones, steps * 1000 / PWM_STEPS - 12, steps * 1000 / PWM_STEPS + 12), "duty");
		chk(steps < PWM_STEPS ? inr(rises, 2, 4) : rises == 0, "period");
		apb(1'b0, ADDR_INFO, 32'h0);
		chk(rdat[8:0] === 9'(steps), "latched high steps");
	endtask

	// ------
	// Scenarios
	// ------
	task automatic t_regs();
		logic [11:0] a [6] = '{ADDR_CFG, ADDR_DUTY, ADDR_STAT, ADDR_MASK, ADDR_CAP, ADDR_THRESH};
		logic [31:0] e [6] = '{32'h0, 32'h2, 32'h0, 32'h0, 32'h3e8, 32'h10};
		for (int i = 0; i < 6; i++)
		begin
			apb(1'b0, a[i], 32'h0);
			chk(rdat === e[i] && perr === 1'b0, "reset value");
		end
		apb(1'b1, 12'h024, 32'hffff_ffff);
		chk(perr === 1'b1, "unmapped write");
		apb(1'b0, 12'h024, 32'h0);
		chk(perr === 1'b1 && rdat === 32'h0, "unmapped read");
		$display("test regs done");
	endtask

	task automatic t_burst(input int cap, input logic [31:0] cfg);
		int n;
		int e;
		e = (SP * PWM_STEPS + DUTY_MIN_STEPS) * CAP_SCALE * cap / ACC_INC;
		apb(1'b1, ADDR_CFG, cfg | 32'h1);
		apb(1'b1, ADDR_CAP, 32'(cap));
		meas(400);
		chk(ones == 0, "pwm low in shutdown");
		apb(1'b0, ADDR_INFO, 32'h0);
		chk(rdat[17:16] === 2'h2, "shut mode");
		apb(1'b1, ADDR_CFG, cfg);
		n = 0;
		while (pwm !== 1'b1 && n < 20)
		begin
			cyc(1);
			n++;
		end
		n = 0;
		while (pwm === 1'b1 && n < 4000)
		begin
			cyc(1);
			n++;
		end
		chk(inr(n, e - 10, e + 10), "burst length");
		apb(1'b0, ADDR_INFO, 32'h0);
		chk(rdat[17:16] === 2'h1, "run mode");
		$display("test burst done");
	endtask

	task automatic t_vin();
		int v [5] = '{1000, 1620, 2110, 2600, 2000};
		for (int i = 0; i < 5; i++)
		begin
			mv <= 12'(v[i]);
			open <= (i == 4);
			duty_case(vsteps(v[i], i == 4));
		end
		open <= 1'b0;
		$display("test vin done");
	endtask

	task automatic t_code();
		apb(1'b1, ADDR_CFG, 32'h0000_0020);
		for (int c = 0; c < 16; c++)
		begin
			apb(1'b1, ADDR_DUTY, 32'(c));
			duty_case(DUTY_MIN_STEPS + c * (PWM_STEPS - DUTY_MIN_STEPS) / 15);
		end
		$display("test code done");
	endtask

	task automatic t_cap();
		apb(1'b1, ADDR_DUTY, 32'h0);
		t_burst(2, 32'h0000_0020);
		meas(2000);
		chk(inr(rises, 2, 4), "period doubles with cap");
		t_burst(1, 32'h0000_0020);
		$display("test cap done");
	endtask

	task automatic t_ot();
		apb(1'b1, ADDR_STAT, 32'h0000_0023);
		apb(1'b1, ADDR_MASK, 32'h0);
		mv <= 12'ha8c;
		cyc(4);
		chk(alert_line === 1'b0 && alert_n === 1'b0, "alert on overtemp");
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rdat === 32'h0000_0020 && irq === 1'b0, "flag set, irq masked");
		apb(1'b1, ADDR_MASK, 32'h0000_0020);
		cyc(1);
		chk(irq === 1'b1, "irq unmasked");
		mv <= 12'h7d0;
		cyc(4);
		chk(alert_line === 1'b1 && irq === 1'b1, "alert released, flag sticky");
		apb(1'b1, ADDR_STAT, 32'h0000_0020);
		cyc(1);
		chk(irq === 1'b0, "irq cleared");
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rdat === 32'h0, "flag cleared");
		$display("test overtemp done");
	endtask

	task automatic t_fan();
		apb(1'b0, ADDR_FAN1, 32'h0);
		chk(inr(rdat, FCNT - 2, FCNT + 2), "fan1 count");
		stall <= 2'h2;
		cyc(1500);
		apb(1'b0, ADDR_FAN2, 32'h0);
		chk(rdat === 32'h0, "stalled count");
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rdat === 32'h0000_0002 && alert_line === 1'b0, "fan2 slow");
		meas(1000);
		chk(inr(rises, 2, 4), "pwm runs on fault");
		stall <= 2'h0;
		slow <= 1'b1;
		apb(1'b1, ADDR_THRESH, 32'h14);
		cyc(1500);
		apb(1'b0, ADDR_FAN1, 32'h0);
		chk(inr(rdat, FCNT / 2 - 2, FCNT / 2 + 2), "slow count");
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rdat[0] === 1'b1 && alert_line === 1'b0, "fan1 below threshold");
		slow <= 1'b0;
		cyc(1500);
		chk(alert_line === 1'b1, "alert released");
		$display("test fan done");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		cyc(3);
		srst <= 1'b0;
		t_regs();
		t_burst(1, 32'h0);
		t_vin();
		t_code();
		t_cap();
		t_ot();
		t_fan();
		wrap_up();
	end

	initial
	begin
		cyc(90000);
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end
endmodule
